//--- common/dflt_pkg.sv
package dflt_pkg;
    // ------------------------------------------------------------
    // Fault word bit positions
    // ------------------------------------------------------------
    localparam int unsigned FW_BIT_CHECKSUM   = 0;
    localparam int unsigned FW_BIT_OVERCUR    = 1;
    localparam int unsigned FW_BIT_OVERVOLT   = 2;
    localparam int unsigned FW_BIT_OVERTEMP   = 4;
    localparam int unsigned FW_BIT_UNDERVOLT  = 5;
    localparam int unsigned FW_BIT_NOTCONFIG  = 6;
    localparam int unsigned FW_BIT_NVMEM      = 8;
    localparam int unsigned FW_BIT_POSSUPPLY  = 10;
    localparam int unsigned FW_BIT_NEGSUPPLY  = 11;
    localparam int unsigned FW_BIT_COMM       = 12;
    localparam int unsigned FW_BIT_FBLOSS     = 14;
    localparam int unsigned FW_FB_BASE        = 16;
    localparam int unsigned FB_BIT_ABBREAK    = 0;
    localparam int unsigned FB_BIT_HALL       = 1;
    localparam int unsigned FB_BIT_INDEX      = 2;
    localparam int unsigned FB_BIT_ENCINIT    = 3;
    localparam int unsigned FB_BIT_SERENC     = 4;
    localparam int unsigned FB_BIT_ABRANGE    = 5;
    localparam int unsigned FB_BIT_MOTTEMP    = 6;
    localparam int unsigned FB_BIT_SINEQUAD   = 7;
    // Bits that may ever be set: low half and feedback-loss causes
    localparam logic [15:0] FW_LOW_USED_MASK  = 16'h5D77;
    localparam logic [15:0] FB_USED_MASK      = 16'h00FF;
    localparam logic [31:0] FW_RESET_VALUE    = 32'h0000_0000;

    // ------------------------------------------------------------
    // Cyclic flags and commands
    // ------------------------------------------------------------
    localparam int unsigned SF_BIT_FAULT      = 15;
    localparam int unsigned SF_BIT_WARNING    = 14;
    localparam int unsigned DF_BIT_COMMLOSS   = 9;
    localparam logic [7:0]  CMD_READ_FAULTS   = 8'h08;

    // ------------------------------------------------------------
    // Feedback checks and thermal figures
    // ------------------------------------------------------------
    localparam logic [2:0]  HALL_BAD_LOW      = 3'h0;
    localparam logic [2:0]  HALL_BAD_HIGH     = 3'h7;
    localparam int unsigned QUAD_MISMATCH_MIN = 2;
    localparam int unsigned QUAD_MOVE_MIN     = 3;
    localparam int unsigned HEATSINK_LIMIT_C  = 80;
    localparam int unsigned I2T_WIDTH         = 32;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_ON,
        PWR_LOCKED
    } dflt_pwr_type;
endpackage

//--- src/dflt_i2t.sv
`timescale 1ns/1ns
`default_nettype none
module dflt_i2t
    import dflt_pkg::*;
#(
    parameter int unsigned CUR_WIDTH = 16,
    parameter int unsigned ACC_WIDTH = I2T_WIDTH,
    parameter int unsigned SHIFT     = 8
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Current sample and rating
    input  wire logic                 sampleValid,
    input  wire logic [CUR_WIDTH-1:0] currentMag,
    input  wire logic [CUR_WIDTH-1:0] ratedCurrent,
    // Foldback state
    output logic                      foldback
);
    typedef struct packed {
        logic [ACC_WIDTH-1:0] acc;
        logic                 fold;
    } dflt_i2t_state_type;

    dflt_i2t_state_type st_q;
    dflt_i2t_state_type st_d;

    function automatic logic [ACC_WIDTH-1:0] square(input logic [CUR_WIDTH-1:0] v);
        logic [2*CUR_WIDTH-1:0] p;
        p = v * v;
        return ACC_WIDTH'(p);
    endfunction

    // ------------------------------------------------------------
    // Leaky average of squared current
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (sampleValid) begin
            st_d.acc = st_q.acc - (st_q.acc >> SHIFT) + (square(currentMag) >> SHIFT);
        end
        st_d.fold = (st_q.acc > square(ratedCurrent));
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign foldback = st_q.fold;
endmodule
`default_nettype wire

//--- src/dflt_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Any fault latches bit, sets flag 15
// - Fault disables stage; re-enable needs clear
// - I2t estimate raises foldback warning
// - Foldback shown on status flag 14
// - Foldback limits current, never disables
// - Bit 14 summarises feedback loss causes
// - Command 0x08 returns latched fault word
// - Over-current cleared only by reset
// - Demand flag bit 9 latches comm fault
// - Comm bit unfiltered, single occurrence latches
// - Bad power-up checksum sets bit 0x0001
// - Heat sink over 80C sets 0x0010
// - Under-voltage 0x0020, over-voltage 0x0004
// - Not configured sets 0x0040
// - Analog supply fails set 0x0400, 0x0800
// - Feedback causes in upper half
// - Hall 000 or 111 flags illegal Hall
// - Quadrant mismatch two samples, moving over three
// - Enable needs all enables, no fault
module dflt_supervisor
    import dflt_pkg::*;
#(
    parameter int unsigned CUR_WIDTH  = 16,
    parameter int unsigned TEMP_WIDTH = 8,
    parameter int unsigned POS_WIDTH  = 32
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Power-up checks
    input  wire logic                  checksumDone,
    input  wire logic                  checksumBad,
    // Power stage and supply monitors
    input  wire logic                  overCurrent,
    input  wire logic                  busOverVolt,
    input  wire logic                  busUnderVolt,
    input  wire logic [TEMP_WIDTH-1:0] heatSinkTemp,
    input  wire logic                  motorNotConfig,
    input  wire logic                  nvMemFault,
    input  wire logic                  posSupplyFail,
    input  wire logic                  negSupplyFail,
    // Feedback monitors
    input  wire logic                  abLineBreak,
    input  wire logic [2:0]            hallState,
    input  wire logic                  indexBreak,
    input  wire logic                  encNotInit,
    input  wire logic                  serialEncFault,
    input  wire logic                  abOutOfRange,
    input  wire logic                  motorOverTemp,
    input  wire logic                  quadSample,
    input  wire logic [1:0]            digitalQuad,
    input  wire logic [1:0]            analogQuad,
    input  wire logic [POS_WIDTH-1:0]  digitalPos,
    // Current for thermal estimate
    input  wire logic                  currentValid,
    input  wire logic [CUR_WIDTH-1:0]  currentMag,
    input  wire logic [CUR_WIDTH-1:0]  ratedCurrent,
    // Network side
    input  wire logic [15:0]           demandFlags,
    input  wire logic                  demandValid,
    input  wire logic                  netReset,
    input  wire logic                  faultClear,
    input  wire logic                  cmdValid,
    input  wire logic [7:0]            cmdCode,
    output logic                       rspValid,
    output logic [31:0]                rspData,
    output logic [15:0]                statusFlags,
    // Enables
    input  wire logic                  remoteEnable,
    input  wire logic                  netEnable,
    input  wire logic                  swEnableSet,
    input  wire logic                  swEnableClr,
    output logic                       powerStageOn,
    output logic                       currentLimit
);
    typedef struct packed {
        logic [31:0]          faultWord;
        logic [1:0]           mismatchCnt;
        logic [POS_WIDTH-1:0] lastPos;
        logic                 swEnable;
        dflt_pwr_type         pwr;
        logic                 rspValid;
        logic [31:0]          rspData;
    } dflt_state_type;

    dflt_state_type st_q;
    dflt_state_type st_d;
    logic           foldback;
    logic [15:0]    lowEvents;
    logic [15:0]    fbEvents;
    logic           quadMove;
    logic           anyCondition;

    function automatic logic [POS_WIDTH-1:0] absDiff(input logic [POS_WIDTH-1:0] a,
                                                     input logic [POS_WIDTH-1:0] b);
        return (a > b) ? (a - b) : (b - a);
    endfunction

    dflt_i2t #(
        .CUR_WIDTH   (CUR_WIDTH)
    ) u_i2t (
        .core_clk    (core_clk),
        .rst         (rst),
        .sampleValid (currentValid),
        .currentMag  (currentMag),
        .ratedCurrent(ratedCurrent),
        .foldback    (foldback)
    );

    // ------------------------------------------------------------
    // Fault event decode
    // ------------------------------------------------------------
    assign quadMove = absDiff(digitalPos, st_q.lastPos) > POS_WIDTH'(QUAD_MOVE_MIN);

    always_comb begin
        fbEvents = '0;
        fbEvents[FB_BIT_ABBREAK]  = abLineBreak;
        fbEvents[FB_BIT_HALL]     = (hallState == HALL_BAD_LOW) ||
                                    (hallState == HALL_BAD_HIGH);
        fbEvents[FB_BIT_INDEX]    = indexBreak;
        fbEvents[FB_BIT_ENCINIT]  = encNotInit;
        fbEvents[FB_BIT_SERENC]   = serialEncFault;
        fbEvents[FB_BIT_ABRANGE]  = abOutOfRange;
        fbEvents[FB_BIT_MOTTEMP]  = motorOverTemp;
        fbEvents[FB_BIT_SINEQUAD] = quadSample && (digitalQuad != analogQuad) && quadMove &&
                                    (st_q.mismatchCnt >= 2'(QUAD_MISMATCH_MIN - 1));
        fbEvents = fbEvents & FB_USED_MASK;

        lowEvents = '0;
        lowEvents[FW_BIT_CHECKSUM]  = checksumDone && checksumBad;
        lowEvents[FW_BIT_OVERCUR]   = overCurrent;
        lowEvents[FW_BIT_OVERVOLT]  = busOverVolt;
        lowEvents[FW_BIT_UNDERVOLT] = busUnderVolt;
        lowEvents[FW_BIT_OVERTEMP]  = heatSinkTemp > TEMP_WIDTH'(HEATSINK_LIMIT_C);
        lowEvents[FW_BIT_NOTCONFIG] = motorNotConfig;
        lowEvents[FW_BIT_NVMEM]     = nvMemFault;
        lowEvents[FW_BIT_POSSUPPLY] = posSupplyFail;
        lowEvents[FW_BIT_NEGSUPPLY] = negSupplyFail;
        lowEvents[FW_BIT_COMM]      = demandValid && demandFlags[DF_BIT_COMMLOSS];
        lowEvents[FW_BIT_FBLOSS]    = |fbEvents;
        lowEvents = lowEvents & FW_LOW_USED_MASK;
    end

    // Level conditions still present block re-enable
    assign anyCondition = |{lowEvents & ~(16'h0001 << FW_BIT_COMM), fbEvents};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rspValid = 1'b0;

        if (quadSample) begin
            st_d.lastPos = digitalPos;
            if ((digitalQuad != analogQuad) && quadMove) begin
                if (st_q.mismatchCnt != 2'h3) begin
                    st_d.mismatchCnt = st_q.mismatchCnt + 2'h1;
                end
            end else begin
                st_d.mismatchCnt = 2'h0;
            end
        end

        // Clearing; over-current survives an ordinary clear, new events win
        if (netReset) begin
            st_d.faultWord = FW_RESET_VALUE;
        end else if (faultClear) begin
            st_d.faultWord = st_q.faultWord & (32'h1 << FW_BIT_OVERCUR);
        end
        st_d.faultWord = st_d.faultWord | {fbEvents, lowEvents};

        if (netReset || swEnableClr) begin
            st_d.swEnable = 1'b0;
        end else if (swEnableSet) begin
            st_d.swEnable = 1'b1;
        end

        case (st_q.pwr)
            PWR_OFF: begin
                if (remoteEnable && netEnable && st_q.swEnable &&
                    (st_q.faultWord == '0) && !anyCondition) begin
                    st_d.pwr = PWR_ON;
                end
            end
            PWR_ON: begin
                if (st_q.faultWord != '0) begin
                    st_d.pwr = PWR_LOCKED;
                end else if (!(remoteEnable && netEnable && st_q.swEnable)) begin
                    st_d.pwr = PWR_OFF;
                end
            end
            PWR_LOCKED: begin
                if ((st_q.faultWord == '0) && !anyCondition) begin
                    st_d.pwr = PWR_OFF;
                    st_d.swEnable = 1'b0;
                end
            end
            default: begin
                st_d.pwr = PWR_OFF;
            end
        endcase

        if (cmdValid && (cmdCode == CMD_READ_FAULTS)) begin
            st_d.rspValid = 1'b1;
            st_d.rspData  = st_q.faultWord;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{faultWord: FW_RESET_VALUE, mismatchCnt: 2'h0, lastPos: '0,
                      swEnable: 1'b0, pwr: PWR_OFF, rspValid: 1'b0, rspData: 32'h0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        statusFlags = '0;
        statusFlags[SF_BIT_FAULT]   = |st_q.faultWord;
        statusFlags[SF_BIT_WARNING] = foldback;
    end

    assign powerStageOn = (st_q.pwr == PWR_ON) && (st_q.faultWord == '0);
    assign currentLimit = foldback;
    assign rspValid     = st_q.rspValid;
    assign rspData      = st_q.rspData;
endmodule
`default_nettype wire

//--- dv/dflt_supervisor_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dflt_supervisor_properties (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Watched ports
    input wire logic        overCurrent,
    input wire logic        remoteEnable,
    input wire logic        netEnable,
    input wire logic        demandValid,
    input wire logic [15:0] demandFlags,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdCode,
    input wire logic        rspValid,
    input wire logic [31:0] rspData,
    input wire logic [15:0] statusFlags,
    input wire logic        powerStageOn,
    input wire logic        currentLimit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_overcur_latch: assert property (
        overCurrent |=> statusFlags[15] && !powerStageOn) else $error("surge not latched");
    a_comm_single: assert property (
        demandValid && demandFlags[9] |=> statusFlags[15]) else $error("comm bit missed");
    a_read_answer: assert property (
        cmdValid && cmdCode == 8'h08 |=> rspValid) else $error("read not answered");
    a_read_only: assert property (
        rspValid |-> $past(cmdValid) && $past(cmdCode) == 8'h08) else $error("stray answer");
    a_unused_zero: assert property (
        rspValid |-> (rspData & 32'hFF00_A288) == 32'h0) else $error("unused bit set");
    a_fbloss_sum: assert property (
        rspValid |-> rspData[14] == (rspData[23:16] != 8'h00)) else $error("summary wrong");
    a_fault_off: assert property (
        powerStageOn |-> !statusFlags[15]) else $error("stage on with fault");
    a_enable_cause: assert property (
        $rose(powerStageOn) |-> $past(remoteEnable) && $past(netEnable))
        else $error("stage on without enables");
    a_warn_limit: assert property (
        statusFlags[14] == currentLimit) else $error("warning and limit differ");
    a_flags_spare: assert property (
        statusFlags[13:0] == 14'h0) else $error("spare flag set");
endmodule
bind dflt_supervisor dflt_supervisor_properties i_dflt_supervisor_properties (
    .core_clk, .rst, .overCurrent, .remoteEnable, .netEnable, .demandValid, .demandFlags,
    .cmdValid, .cmdCode, .rspValid, .rspData, .statusFlags, .powerStageOn, .currentLimit
);
`default_nettype wire

//--- dv/dflt_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module dflt_ctrl_model (
    // Clock
    input wire logic        core_clk,
    // Answer from the drive
    input wire logic        rspValid,
    input wire logic [31:0] rspData,
    // Command and demand side
    output logic            cmdValid,
    output logic [7:0]      cmdCode,
    output logic [15:0]     demandFlags,
    output logic            demandValid
);
    initial begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        demandFlags = 16'hFDFF;
        demandValid = 1'b0;
    end
    // Answer is caught in the one cycle it stands
    task automatic issue(input logic [7:0] code, output logic got, output logic [31:0] word);
        got = 1'b0;
        word = 32'h0;
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmdCode = code;
        repeat (3) begin
            @(negedge core_clk);
            cmdValid = 1'b0;
            cmdCode = ~code;
            if (rspValid === 1'b1 && !got) begin
                got = 1'b1;
                word = rspData;
            end
        end
    endtask
    task automatic send(input logic [15:0] flags);
        @(negedge core_clk);
        demandFlags = flags;
        demandValid = 1'b1;
        @(negedge core_clk);
        demandFlags = ~flags;
        demandValid = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- dv/test_dflt_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module test_dflt_supervisor;
    logic        core_clk = 1'b0, rst = 1'b1, hallHi = 1'b0, quadSample = 1'b0;
    logic        currentValid = 1'b0, netReset = 1'b0, faultClear = 1'b0;
    logic        remoteEnable = 1'b0, netEnable = 1'b0, swEnableSet = 1'b0, swEnableClr = 1'b0;
    logic [15:0] src = 16'h0, currentMag = 16'h0010, ratedCurrent = 16'h0100;
    logic [6:0]  fb = 7'h0;
    logic [1:0]  digitalQuad = 2'h0, analogQuad = 2'h0;
    logic [31:0] digitalPos = 32'h0, rspData, word, m;
    logic [15:0] demandFlags, statusFlags;
    logic [7:0]  cmdCode;
    logic        cmdValid, demandValid, rspValid, powerStageOn, currentLimit, got;
    integer      seed = 32'h7501, miscompares = 0, total_checks = 0, i;
    always #25 core_clk = ~core_clk;
    dflt_supervisor i_dflt_supervisor (
        .core_clk, .rst, .checksumDone(src[0]), .checksumBad(src[0]), .overCurrent(src[1]),
        .busOverVolt(src[2]), .busUnderVolt(src[5]), .heatSinkTemp(src[4] ? 8'h51 : 8'h50),
        .motorNotConfig(src[6]), .nvMemFault(src[8]), .posSupplyFail(src[10]),
        .negSupplyFail(src[11]), .abLineBreak(fb[0]), .hallState(fb[1] ? {3{hallHi}} : 3'h3),
        .indexBreak(fb[2]), .encNotInit(fb[3]), .serialEncFault(fb[4]), .abOutOfRange(fb[5]),
        .motorOverTemp(fb[6]), .quadSample, .digitalQuad, .analogQuad, .digitalPos,
        .currentValid, .currentMag, .ratedCurrent, .demandFlags, .demandValid, .netReset,
        .faultClear, .cmdValid, .cmdCode, .rspValid, .rspData, .statusFlags, .remoteEnable,
        .netEnable, .swEnableSet, .swEnableClr, .powerStageOn, .currentLimit
    );
    dflt_ctrl_model i_dflt_ctrl_model (
        .core_clk, .rspValid, .rspData, .cmdValid, .cmdCode, .demandFlags, .demandValid
    );
    function automatic logic [31:0] exp_word(input logic [15:0] s, input logic [6:0] f);
        return {9'h0, f, s & 16'h0D77} | ((f != 7'h0) ? 32'h4000 : 32'h0);
    endfunction
    task automatic check(input logic [31:0] val, input logic [31:0] exp);
        total_checks++;
        if (val !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, val, exp);
        end
    endtask
    task automatic read_check(input logic [31:0] exp);
        i_dflt_ctrl_model.issue(8'h08, got, word);
        check(word, exp);
    endtask
    task automatic fire(input logic [15:0] s, input logic [6:0] f);
        @(negedge core_clk);
        src = s;
        fb = f;
        hallHi = 1'($random(seed));
        @(negedge core_clk);
        src = 16'h0;
        fb = 7'h0;
    endtask
    // k: 0 network reset, 1 fault clear, 2 enable set, 3 enable clear
    task automatic strobe(input int k);
        @(negedge core_clk);
        {swEnableClr, swEnableSet, faultClear, netReset} = 4'h1 << k;
        @(negedge core_clk);
        {swEnableClr, swEnableSet, faultClear, netReset} = 4'h0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic quad(input logic mis, input logic [31:0] step);
        @(negedge core_clk);
        quadSample = 1'b1;
        digitalQuad = digitalQuad + 2'h1;
        analogQuad = digitalQuad ^ {1'b0, mis};
        digitalPos = digitalPos + step;
        @(negedge core_clk);
        quadSample = 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        read_check(32'h0);
        for (i = 0; i < 23; i++) begin
            m = 32'h1 << i;
            fire(m[15:0], m[22:16]);
            check(32'(statusFlags[15]), 32'(exp_word(m[15:0], m[22:16]) != 32'h0));
            read_check(exp_word(m[15:0], m[22:16]));
            strobe(0);
        end
        $display("test single sources done");
        fire(16'h0002, 7'h0);
        strobe(1);
        read_check(32'h0002);
        strobe(0);
        read_check(32'h0);
        i_dflt_ctrl_model.send(16'h0200);
        read_check(32'h1000);
        strobe(1);
        read_check(32'h0);
        $display("test clear paths done");
        remoteEnable = 1'b1;
        netEnable = 1'b1;
        strobe(2);
        check({31'h0, powerStageOn}, 32'h1);
        fire(16'h0010, 7'h0);
        check({31'h0, powerStageOn}, 32'h0);
        strobe(1);
        check({31'h0, powerStageOn}, 32'h0);
        strobe(2);
        check({31'h0, powerStageOn}, 32'h1);
        currentMag = 16'h0200;
        currentValid = 1'b1;
        for (i = 0; i < 1000 && statusFlags[14] !== 1'b1; i++) @(negedge core_clk);
        if (i == 1000) begin
            miscompares++;
            finish_test();
        end
        check({31'h0, currentLimit}, 32'h1);
        check({31'h0, powerStageOn}, 32'h1);
        currentMag = 16'h0010;
        strobe(3);
        check({31'h0, powerStageOn}, 32'h0);
        $display("test enable and foldback done");
        quad(0, 4);
        quad(1, 4);
        quad(1, 4);
        read_check(32'h0080_4000);
        strobe(0);
        quad(0, 4);
        quad(1, 4);
        quad(0, 4);
        quad(1, 4);
        quad(1, 3);
        quad(1, 3);
        read_check(32'h0);
        $display("test quadrant done");
        for (i = 0; i < 20; i++) begin
            m = $random(seed);
            fire(m[15:0], m[22:16]);
            read_check(exp_word(m[15:0], m[22:16]));
            strobe(0);
            i_dflt_ctrl_model.issue(m[31:24] == 8'h08 ? 8'h09 : m[31:24], got, word);
            check({31'h0, got}, 32'h0);
        end
        $display("test random done");
        finish_test();
    end
endmodule
`default_nettype wire
